// file: pkg/cpm_pkg.sv
// control port pin mux: shared constants and types.
// assumes one core clock domain plus the slave serial clock taken from the link.
// Operation
// [RULE1] device reset begins on a falling reset pin edge, ends on rising edge.
// [RULE2] every reset event returns all state of the block to its defaults; the code keeps the reset and toggle histories and the link frame state.
// [RULE3] spi master select line driven low during a transaction, high otherwise.
// [RULE4] boot select high at reset release latches multipurpose pin 0 as boot protocol.
// [RULE5] pin 0 floating (pulled high) selects spi boot; pulled low selects i2c.
// [RULE6] spi master sends serial data on multipurpose pin 1.
// [RULE7] i2c master clock is open-collector, never driven high.
// [RULE8] spi master clock leaves on the same pin as the i2c master clock.
// [RULE9] i2c master data is a shared bidirectional open-collector line.
// [RULE10] spi master receives slave data on the i2c master data pin.
// [RULE11] spi slave read data leaves on the slave data-output pin.
// [RULE12] in i2c slave mode that pin is bidirectional open-collector data.
// [RULE13] external master supplies the slave clock; the device only receives it.
// [RULE14] external master drives spi slave write data on the data-input pin.
// [RULE15] external master drives slave select to frame each spi transaction.
// [RULE16] i2c slave address bits: data-input pin high bit, select pin low bit.
// [RULE17] software can switch off the internal pull-up of each control pin.
// [RULE18] boot select high starts eeprom boot at next reset release; low means none.
// [RULE19] each master pin owned by exactly one of spi, i2c or gpio per mode.
package cpm_pkg;
  localparam int NUM_MP = 4;
  localparam int NUM_PULL = 8;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [NUM_PULL-1:0] PULL_EN_DEFAULT = 8'hff;
  localparam logic [BYTE_W-1:0] TX_DEFAULT = 8'h00;

  // bit positions inside the synchronised input vector
  localparam int SYN_W = 10;
  localparam int SYN_RSTN = 0;
  localparam int SYN_BOOT = 1;
  localparam int SYN_MP_LO = 2;
  localparam int SYN_MOSI = 6;
  localparam int SYN_SS = 7;
  localparam int SYN_RXTOG = 8;
  localparam int SYN_SDA_S = 9;

  // master pin indices
  localparam int MP_SEL = 0;
  localparam int MP_DOUT = 1;
  localparam int MP_CLK = 2;
  localparam int MP_DIN = 3;

  typedef enum logic [1:0]
  {
    CPM_MODE_GPIO = 2'h0,
    CPM_MODE_SPI = 2'h1,
    CPM_MODE_I2C = 2'h2
  } cpm_mport_mode_t;

  typedef enum logic [1:0]
  {
    CPM_ST_HELD = 2'h1,
    CPM_ST_RUN = 2'h2
  } cpm_dev_state_t;

  typedef struct packed
  {
    logic [NUM_MP-1:0] o;
    logic [NUM_MP-1:0] oe;
  } cpm_mp_drive_t;

  typedef struct packed
  {
    logic scl_low;
    logic sda_low;
  } cpm_i2c_m_req_t;

  typedef struct packed
  {
    logic cs_active;
    logic sclk;
    logic mosi;
  } cpm_spi_m_req_t;

  typedef struct packed
  {
    cpm_dev_state_t st;
    logic rstn_prev;
    logic dev_reset;
    logic boot_start;
    logic boot_i2c;
    logic [NUM_PULL-1:0] pull_en;
    cpm_mp_drive_t mp;
    logic spi_m_miso;
    logic i2c_m_scl_in;
    logic i2c_m_sda_in;
    logic [NUM_MP-1:0] gpio_in;
    logic [1:0] i2c_addr;
    logic i2c_s_sda_oe;
    logic i2c_s_sda_in;
    logic rxtog_prev;
    logic [BYTE_W-1:0] rx_byte;
    logic rx_valid;
  } cpm_core_state_t;

  typedef struct packed
  {
    logic [CNT_W-1:0] cnt;
    logic [BYTE_W-1:0] rx_sh;
    logic [BYTE_W-1:0] tx_sh;
    logic sdo_oe;
  } cpm_link_state_t;
endpackage

// file: hw/cpm_sync2.sv
// two flip-flop synchroniser for a vector of independent levels.
// assumes each bit is a quasi-static level; bits are not coherent with each other.
`timescale 1ns/1ps
module cpm_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cpm_sync_state_t;

  cpm_sync_state_t s_reg;
  cpm_sync_state_t s_next;

  always_comb
  begin
    s_next.meta = async_i;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.stable;
endmodule

// file: hw/cpm_slave_link.sv
// spi slave shifter running on the externally supplied slave clock.
// assumes the clock only toggles inside a frame; slave select high clears the frame state.
`timescale 1ns/1ps
module cpm_slave_link (
  input wire logic slave_clk_i,
  input wire logic frame_clear_i,
  input wire logic link_rst_i,
  input wire logic mosi_i,
  input wire logic [cpm_pkg::BYTE_W-1:0] tx_byte_i,
  output logic [cpm_pkg::BYTE_W-1:0] rx_byte_o,
  output logic rx_toggle_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  cpm_pkg::cpm_link_state_t s_reg;
  cpm_pkg::cpm_link_state_t s_next;
  logic tog_reg;
  logic tog_next;
  logic [cpm_pkg::BYTE_W-1:0] hold_reg;
  logic [cpm_pkg::BYTE_W-1:0] hold_next;

  always_comb
  begin
    s_next = s_reg;
    tog_next = tog_reg;
    hold_next = hold_reg;
    s_next.sdo_oe = 1'b1;
    s_next.cnt = s_reg.cnt + 3'h1;
    s_next.rx_sh = {s_reg.rx_sh[cpm_pkg::BYTE_W-2:0], mosi_i}; // [RULE14]
    // the next byte is taken at the first edge of each byte, so it leaves one bit late
    if (s_reg.cnt == '0)
    begin
      s_next.tx_sh = tx_byte_i;
    end
    else
    begin
      s_next.tx_sh = {s_reg.tx_sh[cpm_pkg::BYTE_W-2:0], 1'b0};
    end
    if (s_reg.cnt == cpm_pkg::LAST_BIT)
    begin
      hold_next = {s_reg.rx_sh[cpm_pkg::BYTE_W-2:0], mosi_i}; // [RULE14]
      tog_next = ~tog_reg;
    end
  end

  // frame state ends with the frame's own select, since the clock stops with it
  always_ff @(posedge slave_clk_i or posedge frame_clear_i)
  begin
    if (frame_clear_i)
    begin
      s_reg <= '0; // [RULE15]
    end
    else
    begin
      s_reg <= s_next; // [RULE13]
    end
  end

  // toggle and byte survive frame ends: the core picks the byte up only after
  // the toggle has crossed, which is well after the select has gone high
  always_ff @(posedge slave_clk_i or posedge link_rst_i)
  begin
    if (link_rst_i)
    begin
      tog_reg <= 1'b0;
      hold_reg <= '0;
    end
    else
    begin
      tog_reg <= tog_next;
      hold_reg <= hold_next;
    end
  end

  assign rx_byte_o = hold_reg;
  assign rx_toggle_o = tog_reg;
  assign sdo_o = s_reg.tx_sh[cpm_pkg::BYTE_W-1]; // [RULE11]
  assign sdo_oe_o = s_reg.sdo_oe;
endmodule

// file: hw/cpm_top.sv
// control port pin mux: reset edges, boot protocol strap, master and slave port pins.
// assumes the slave serial clock is a clock port; all other pins are synchronised here.
`timescale 1ns/1ps
module cpm_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic slave_clk_i,
  input wire logic reset_pin_n_i,
  input wire logic boot_from_eeprom_select_i,
  input wire logic [cpm_pkg::NUM_MP-1:0] multipurpose_io_i,
  output logic [cpm_pkg::NUM_MP-1:0] multipurpose_io_o,
  output logic [cpm_pkg::NUM_MP-1:0] multipurpose_io_oe_o,
  input wire logic slave_mosi_i,
  input wire logic slave_ss_n_i,
  input wire logic slave_sdo_i,
  output logic slave_sdo_o,
  output logic slave_sdo_oe_o,
  input wire cpm_pkg::cpm_mport_mode_t mport_mode_i,
  input wire logic slave_is_i2c_i,
  input wire logic pullup_wr_i,
  input wire logic [cpm_pkg::NUM_PULL-1:0] pullup_disable_i,
  output logic [cpm_pkg::NUM_PULL-1:0] pullup_en_o,
  output logic dev_reset_o,
  output logic boot_start_o,
  output logic boot_use_i2c_o,
  input wire cpm_pkg::cpm_spi_m_req_t spi_m_req_i,
  output logic spi_m_miso_o,
  input wire cpm_pkg::cpm_i2c_m_req_t i2c_m_req_i,
  output logic i2c_m_scl_in_o,
  output logic i2c_m_sda_in_o,
  input wire logic [cpm_pkg::NUM_MP-1:0] gpio_out_i,
  input wire logic [cpm_pkg::NUM_MP-1:0] gpio_oe_i,
  output logic [cpm_pkg::NUM_MP-1:0] gpio_in_o,
  input wire logic i2c_s_sda_low_i,
  output logic i2c_s_sda_in_o,
  output logic [1:0] i2c_s_addr_o,
  input wire logic [cpm_pkg::BYTE_W-1:0] spi_s_tx_byte_i,
  output logic [cpm_pkg::BYTE_W-1:0] spi_s_rx_byte_o,
  output logic spi_s_rx_valid_o
);
  cpm_pkg::cpm_core_state_t s_reg;
  cpm_pkg::cpm_core_state_t s_next;
  logic [cpm_pkg::SYN_W-1:0] syn_raw;
  logic [cpm_pkg::SYN_W-1:0] syn;
  logic [cpm_pkg::BYTE_W-1:0] link_rx_byte;
  logic link_rx_tog;
  logic link_sdo;
  logic link_sdo_oe;
  logic [cpm_pkg::NUM_MP-1:0] mp_in;
  logic rst_rise;
  logic rst_fall;

  // defaults that every reset event restores, apart from the reset tracker and the receive toggle history
  function automatic cpm_pkg::cpm_core_state_t cpm_defaults(
    input cpm_pkg::cpm_core_state_t cur
  );
    cpm_pkg::cpm_core_state_t d;
    d = '0;
    d.st = cur.st;
    d.rstn_prev = cur.rstn_prev;
    d.pull_en = cpm_pkg::PULL_EN_DEFAULT;
    d.i2c_m_scl_in = 1'b1;
    d.i2c_m_sda_in = 1'b1;
    d.i2c_s_sda_in = 1'b1;
    d.rxtog_prev = cur.rxtog_prev;
    return d;
  endfunction

  assign syn_raw = {slave_sdo_i, link_rx_tog, slave_ss_n_i, slave_mosi_i,
    multipurpose_io_i, boot_from_eeprom_select_i, reset_pin_n_i};

  cpm_sync2 #(
    .WIDTH(cpm_pkg::SYN_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(syn_raw),
    .sync_o(syn)
  );

  cpm_slave_link u_link (
    .slave_clk_i(slave_clk_i),
    .frame_clear_i(slave_ss_n_i),
    .link_rst_i(s_reg.dev_reset),
    .mosi_i(slave_mosi_i),
    .tx_byte_i(spi_s_tx_byte_i),
    .rx_byte_o(link_rx_byte),
    .rx_toggle_o(link_rx_tog),
    .sdo_o(link_sdo),
    .sdo_oe_o(link_sdo_oe)
  );

  assign mp_in = syn[cpm_pkg::SYN_MP_LO +: cpm_pkg::NUM_MP];
  assign rst_rise = syn[cpm_pkg::SYN_RSTN] && !s_reg.rstn_prev;
  assign rst_fall = !syn[cpm_pkg::SYN_RSTN] && s_reg.rstn_prev;

  always_comb
  begin
    s_next = s_reg;
    s_next.rstn_prev = syn[cpm_pkg::SYN_RSTN];
    s_next.boot_start = 1'b0;
    s_next.rx_valid = 1'b0;
    s_next.rxtog_prev = syn[cpm_pkg::SYN_RXTOG];
    case (s_reg.st)
      cpm_pkg::CPM_ST_HELD:
      begin
        s_next = cpm_defaults(s_next); // [RULE2]
        s_next.dev_reset = 1'b1;
        if (rst_rise)
        begin
          s_next.st = cpm_pkg::CPM_ST_RUN; // [RULE1]
          s_next.dev_reset = 1'b0;
          s_next.boot_start = syn[cpm_pkg::SYN_BOOT]; // [RULE18]
          if (syn[cpm_pkg::SYN_BOOT])
          begin
            // the pin's pull-up reads high when floating, so high means spi
            s_next.boot_i2c = !mp_in[cpm_pkg::MP_SEL]; // [RULE4] [RULE5]
          end
        end
      end
      cpm_pkg::CPM_ST_RUN:
      begin
        if (rst_fall)
        begin
          s_next = cpm_defaults(s_next); // [RULE1] [RULE2]
          s_next.st = cpm_pkg::CPM_ST_HELD;
          s_next.dev_reset = 1'b1;
        end
        else
        begin
          if (pullup_wr_i)
          begin
            s_next.pull_en = ~pullup_disable_i; // [RULE17]
          end
          s_next.mp.o = '0;
          s_next.mp.oe = '0;
          s_next.gpio_in = '0;
          s_next.spi_m_miso = 1'b0;
          s_next.i2c_m_scl_in = 1'b1;
          s_next.i2c_m_sda_in = 1'b1;
          case (mport_mode_i)
            cpm_pkg::CPM_MODE_SPI:
            begin
              s_next.mp.o[cpm_pkg::MP_SEL] = !spi_m_req_i.cs_active; // [RULE3]
              s_next.mp.oe[cpm_pkg::MP_SEL] = 1'b1;
              s_next.mp.o[cpm_pkg::MP_DOUT] = spi_m_req_i.mosi; // [RULE6]
              s_next.mp.oe[cpm_pkg::MP_DOUT] = 1'b1;
              s_next.mp.o[cpm_pkg::MP_CLK] = spi_m_req_i.sclk; // [RULE8]
              s_next.mp.oe[cpm_pkg::MP_CLK] = 1'b1;
              s_next.spi_m_miso = mp_in[cpm_pkg::MP_DIN]; // [RULE10]
            end
            cpm_pkg::CPM_MODE_I2C:
            begin
              // open collector: output value stays low, only the enable moves
              s_next.mp.oe[cpm_pkg::MP_CLK] = i2c_m_req_i.scl_low; // [RULE7]
              s_next.mp.oe[cpm_pkg::MP_DIN] = i2c_m_req_i.sda_low; // [RULE9]
              s_next.i2c_m_scl_in = mp_in[cpm_pkg::MP_CLK];
              s_next.i2c_m_sda_in = mp_in[cpm_pkg::MP_DIN]; // [RULE9]
            end
            cpm_pkg::CPM_MODE_GPIO:
            begin
              s_next.mp.o = gpio_out_i;
              s_next.mp.oe = gpio_oe_i;
              s_next.gpio_in = mp_in;
            end
            default:
            begin
              // unknown mode owns nothing: all pins released [RULE19]
              s_next.mp.oe = '0;
            end
          endcase
          if (slave_is_i2c_i)
          begin
            s_next.i2c_addr = {syn[cpm_pkg::SYN_MOSI], syn[cpm_pkg::SYN_SS]}; // [RULE16]
            s_next.i2c_s_sda_oe = i2c_s_sda_low_i; // [RULE12]
            s_next.i2c_s_sda_in = syn[cpm_pkg::SYN_SDA_S]; // [RULE12]
          end
          else
          begin
            s_next.i2c_s_sda_oe = 1'b0;
            s_next.i2c_s_sda_in = 1'b1;
            if (syn[cpm_pkg::SYN_RXTOG] != s_reg.rxtog_prev)
            begin
              s_next.rx_byte = link_rx_byte;
              s_next.rx_valid = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_next = cpm_defaults(s_next);
        s_next.st = cpm_pkg::CPM_ST_HELD;
        s_next.dev_reset = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.st <= cpm_pkg::CPM_ST_HELD;
      s_reg.dev_reset <= 1'b1;
      s_reg.pull_en <= cpm_pkg::PULL_EN_DEFAULT;
      s_reg.i2c_m_scl_in <= 1'b1;
      s_reg.i2c_m_sda_in <= 1'b1;
      s_reg.i2c_s_sda_in <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign multipurpose_io_o = s_reg.mp.o; // [RULE19]
  assign multipurpose_io_oe_o = s_reg.mp.oe; // [RULE19]
  // slave pin: spi data from the link domain, or open-collector i2c data
  assign slave_sdo_o = slave_is_i2c_i ? 1'b0 : link_sdo; // [RULE11] [RULE12]
  assign slave_sdo_oe_o = slave_is_i2c_i ? s_reg.i2c_s_sda_oe
    : (link_sdo_oe && !s_reg.dev_reset);
  assign pullup_en_o = s_reg.pull_en;
  assign dev_reset_o = s_reg.dev_reset;
  assign boot_start_o = s_reg.boot_start;
  assign boot_use_i2c_o = s_reg.boot_i2c;
  assign spi_m_miso_o = s_reg.spi_m_miso;
  assign i2c_m_scl_in_o = s_reg.i2c_m_scl_in;
  assign i2c_m_sda_in_o = s_reg.i2c_m_sda_in;
  assign gpio_in_o = s_reg.gpio_in;
  assign i2c_s_sda_in_o = s_reg.i2c_s_sda_in;
  assign i2c_s_addr_o = s_reg.i2c_addr;
  assign spi_s_rx_byte_o = s_reg.rx_byte;
  assign spi_s_rx_valid_o = s_reg.rx_valid;
endmodule

// file: tb/cpm_assertions.sv
// checker: master pin routing, open-collector drive, reset defaults, boot pulse.
// assumes it is bound to cpm_top and sees only the top module's ports.
`timescale 1ns/1ps
module cpm_assertions (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire cpm_pkg::cpm_mport_mode_t mport_mode_i,
  input wire cpm_pkg::cpm_spi_m_req_t spi_m_req_i,
  input wire cpm_pkg::cpm_i2c_m_req_t i2c_m_req_i,
  input wire logic [3:0] gpio_out_i,
  input wire logic [3:0] gpio_oe_i,
  input wire logic [3:0] multipurpose_io_o,
  input wire logic [3:0] multipurpose_io_oe_o,
  input wire logic pullup_wr_i,
  input wire logic [7:0] pullup_disable_i,
  input wire logic [7:0] pullup_en_o,
  input wire logic dev_reset_o,
  input wire logic boot_start_o,
  input wire logic slave_is_i2c_i,
  input wire logic i2c_s_sda_low_i,
  input wire logic slave_sdo_o,
  input wire logic slave_sdo_oe_o,
  input wire logic slave_mosi_i,
  input wire logic slave_ss_n_i,
  input wire logic [1:0] i2c_s_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // live: the pins now show last cycle's requests, with no reset on either side
  logic run_reg;
  logic spi_reg;
  logic i2c_reg;
  logic gpio_reg;
  logic live;
  always_ff @(posedge core_clk_i)
  begin
    run_reg <= !rst_i && !dev_reset_o;
    spi_reg <= mport_mode_i == cpm_pkg::CPM_MODE_SPI;
    i2c_reg <= mport_mode_i == cpm_pkg::CPM_MODE_I2C;
    gpio_reg <= mport_mode_i == cpm_pkg::CPM_MODE_GPIO;
  end
  assign live = run_reg && !dev_reset_o;
  a_spi_select: assert property (
    live && spi_reg |-> multipurpose_io_oe_o[0]
    && multipurpose_io_o[0] == !$past(spi_m_req_i.cs_active))
    else $error("spi select pin does not follow the transaction");
  a_spi_clk_data: assert property (
    live && spi_reg |-> multipurpose_io_oe_o[2:1] == 2'h3
    && multipurpose_io_o[2:1] == {$past(spi_m_req_i.sclk), $past(spi_m_req_i.mosi)})
    else $error("spi clock or data pin wrong");
  a_i2c_clk_od: assert property (
    live && i2c_reg |-> !multipurpose_io_o[2]
    && multipurpose_io_oe_o[2] == $past(i2c_m_req_i.scl_low))
    else $error("i2c master clock not open collector");
  a_i2c_data_od: assert property (
    live && i2c_reg |-> !multipurpose_io_o[3]
    && multipurpose_io_oe_o[3] == $past(i2c_m_req_i.sda_low))
    else $error("i2c master data not open collector");
  a_gpio_owner: assert property (
    live && gpio_reg |-> multipurpose_io_oe_o == $past(gpio_oe_i)
    && (multipurpose_io_o & multipurpose_io_oe_o) == ($past(gpio_out_i) & multipurpose_io_oe_o))
    else $error("gpio does not own the master pins");
  a_reset_dflt: assert property (
    dev_reset_o |-> multipurpose_io_oe_o == 4'h0 && pullup_en_o == 8'hff)
    else $error("defaults not held during device reset");
  a_pullup_wr: assert property (
    pullup_wr_i && !dev_reset_o |=> dev_reset_o || pullup_en_o == ~$past(pullup_disable_i))
    else $error("pull-up write not applied");
  a_boot_pulse: assert property (
    boot_start_o |-> $past(dev_reset_o) && !dev_reset_o ##1 !boot_start_o)
    else $error("boot start not a single pulse at reset release");
  a_slave_od: assert property (
    live && slave_is_i2c_i && $past(slave_is_i2c_i) |-> !slave_sdo_o
    && slave_sdo_oe_o == $past(i2c_s_sda_low_i))
    else $error("slave data not open collector");
  a_addr_bits: assert property (
    (live && slave_is_i2c_i && $stable({slave_mosi_i, slave_ss_n_i}))[*5]
    |-> i2c_s_addr_o == {slave_mosi_i, slave_ss_n_i})
    else $error("i2c address bits wrong");
endmodule

// file: tb/cpm_host_model.sv
// external spi host on the slave port; resolves the slave data pin.
// assumes the device drives that pin only while its enable is high.
`timescale 1ns/1ps
module cpm_host_model (
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic slave_clk_o,
  output logic ss_n_o,
  output logic mosi_o,
  output logic sdo_pin_o
);
  // released line rests on its pull-up
  assign sdo_pin_o = sdo_oe_i ? sdo_i : 1'b1;
  initial
  begin
    slave_clk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic pins(input logic m, input logic s);
    mosi_o = m;
    ss_n_o = s;
  endtask
  // 32 ns serial clock, still outside the frame
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    ss_n_o = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--)
    begin
      mosi_o = tx[i];
      #16 slave_clk_o = 1'b1;
      #16 slave_clk_o = 1'b0;
      rx[i] = sdo_pin_o;
    end
    #40 ss_n_o = 1'b1;
    mosi_o = !tx[0];
  endtask
endmodule

// file: tb/tb_cpm_top.sv
// testbench for the control port pin mux: reset, boot strap, master and slave pins.
// assumes a 10 MHz core clock and the host model on the slave port.
`timescale 1ns/1ps
module tb_cpm_top;
  logic clk = 1'b0, rst = 1'b1, rpin_n = 1'b0, boot = 1'b0, pwr = 1'b0;
  logic s_i2c = 1'b0, s_low = 1'b0;
  logic [3:0] strap = 4'hf, gout = 4'h0, goe = 4'h0, mo, moe, mpin, gin;
  logic [7:0] pdis = 8'h00, stx = 8'h00, pen, srx, got_rx, hrx;
  logic [7:0] tab [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
  logic [1:0] addr;
  logic drst, bst, bi2c, miso, scl_in, sda_in, s_in, rxv, sdo, sdo_oe, sdo_pin, sclk, ss_n, mosi;
  cpm_pkg::cpm_mport_mode_t mode = cpm_pkg::CPM_MODE_GPIO;
  cpm_pkg::cpm_spi_m_req_t sreq = 3'h0;
  cpm_pkg::cpm_i2c_m_req_t ireq = 2'h0;
  int err_total = 0, compares = 0, boots = 0, nrx = 0, cyc = 0;
  // open pins settle on the strap level, driven pins on the device value
  assign mpin = (moe & mo) | (~moe & strap);
  cpm_top u_cpm_top (.core_clk_i(clk), .rst_i(rst), .slave_clk_i(sclk),
    .reset_pin_n_i(rpin_n), .boot_from_eeprom_select_i(boot), .multipurpose_io_i(mpin),
    .multipurpose_io_o(mo), .multipurpose_io_oe_o(moe), .slave_mosi_i(mosi),
    .slave_ss_n_i(ss_n), .slave_sdo_i(sdo_pin), .slave_sdo_o(sdo), .slave_sdo_oe_o(sdo_oe),
    .mport_mode_i(mode), .slave_is_i2c_i(s_i2c), .pullup_wr_i(pwr), .pullup_disable_i(pdis),
    .pullup_en_o(pen), .dev_reset_o(drst), .boot_start_o(bst), .boot_use_i2c_o(bi2c),
    .spi_m_req_i(sreq), .spi_m_miso_o(miso), .i2c_m_req_i(ireq), .i2c_m_scl_in_o(scl_in),
    .i2c_m_sda_in_o(sda_in), .gpio_out_i(gout), .gpio_oe_i(goe), .gpio_in_o(gin),
    .i2c_s_sda_low_i(s_low), .i2c_s_sda_in_o(s_in), .i2c_s_addr_o(addr),
    .spi_s_tx_byte_i(stx), .spi_s_rx_byte_o(srx), .spi_s_rx_valid_o(rxv));
  cpm_host_model u_cpm_host_model (.sdo_i(sdo), .sdo_oe_i(sdo_oe), .slave_clk_o(sclk),
    .ss_n_o(ss_n), .mosi_o(mosi), .sdo_pin_o(sdo_pin));
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (bst === 1'b1) boots++;
    if (rxv === 1'b1)
    begin
      got_rx = srx;
      nrx++;
    end
    if (cyc == 3000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_dev(logic v);
    for (int k = 0; k < 40 && drst !== v; k++) step(1);
    chk(drst, v);
  endtask
  task automatic final_report();
    $display("mismatches %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    step(20);
    rst = 1'b0;
    step(4);
    chk(drst, 1);
    chk({pen, moe}, {8'hff, 4'h0});
    boot = 1'b1;
    strap[0] = 1'b0;
    rpin_n = 1'b1;
    wait_dev(0);
    step(1);
    chk({bi2c, boots[1:0]}, 3'h5);
    pwr = 1'b1;
    pdis = 8'h01;
    step(1);
    chk(pen, 8'hfe);
    pdis = 8'h80;
    step(1);
    chk(pen, 8'h7f);
    pwr = 1'b0;
    rpin_n = 1'b0;
    strap[0] = 1'b1;
    wait_dev(1);
    chk(pen, 8'hff);
    rpin_n = 1'b1;
    wait_dev(0);
    step(1);
    chk({bi2c, boots[1:0]}, 3'h2);
    boot = 1'b0;
    rpin_n = 1'b0;
    wait_dev(1);
    rpin_n = 1'b1;
    wait_dev(0);
    step(2);
    chk(boots, 2);
    mode = cpm_pkg::CPM_MODE_SPI;
    sreq = 3'h6;
    strap[3] = 1'b0;
    step(4);
    chk({moe, mo}, 8'h74);
    chk(miso, 0);
    strap[3] = 1'b1;
    sreq = 3'h1;
    step(4);
    chk({mo[2:0], miso}, 4'h7);
    mode = cpm_pkg::CPM_MODE_I2C;
    ireq = 2'h2;
    step(4);
    chk({moe[3:2], mo[3:2], scl_in, sda_in}, 6'h11);
    ireq = 2'h1;
    step(4);
    chk({moe[3:2], mo[3:2], scl_in, sda_in}, 6'h22);
    mode = cpm_pkg::CPM_MODE_GPIO;
    gout = 4'ha;
    goe = 4'h3;
    strap = 4'h4;
    step(4);
    chk({moe, mo & moe, gin}, {4'h3, 4'h2, 4'h6});
    mode = cpm_pkg::cpm_mport_mode_t'(2'h3);
    strap = 4'hf;
    step(2);
    chk(moe, 0);
    for (int i = 0; i < 2; i++)
    begin
      stx = tab[2 * i + 1];
      u_cpm_host_model.frame(tab[2 * i], hrx);
      step(8);
      chk(got_rx, tab[2 * i]);
      chk({hrx, sdo_oe}, {tab[2 * i + 1], 1'b0});
    end
    chk(nrx, 2);
    s_i2c = 1'b1;
    u_cpm_host_model.pins(1'b1, 1'b0);
    step(6);
    chk(addr, 2'h2);
    u_cpm_host_model.pins(1'b0, 1'b1);
    s_low = 1'b1;
    step(6);
    chk({addr, sdo_oe, sdo, s_in}, 5'h0c);
    s_low = 1'b0;
    step(4);
    chk({sdo_oe, s_in}, 2'h1);
    final_report();
  end
endmodule
bind cpm_top cpm_assertions u_cpm_assertions (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .mport_mode_i(mport_mode_i), .spi_m_req_i(spi_m_req_i), .i2c_m_req_i(i2c_m_req_i),
  .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .multipurpose_io_o(multipurpose_io_o),
  .multipurpose_io_oe_o(multipurpose_io_oe_o), .pullup_wr_i(pullup_wr_i),
  .pullup_disable_i(pullup_disable_i), .pullup_en_o(pullup_en_o), .dev_reset_o(dev_reset_o),
  .boot_start_o(boot_start_o), .slave_is_i2c_i(slave_is_i2c_i),
  .i2c_s_sda_low_i(i2c_s_sda_low_i), .slave_sdo_o(slave_sdo_o),
  .slave_sdo_oe_o(slave_sdo_oe_o), .slave_mosi_i(slave_mosi_i),
  .slave_ss_n_i(slave_ss_n_i), .i2c_s_addr_o(i2c_s_addr_o));
